// [hdl/cmd_lock_fsm.sv]
// module: command state machine for paused-erase buffered program, blank check, lock, factory program
`timescale 1ns/1ns
module cmd_lock_fsm
  import cmd_lock_pkg::*;
#(
  parameter int CNT_W = 5
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_strobe,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic engine_done,
  input wire logic status_bit_zero,
  input wire logic [1:0] reg_addr,
  input wire logic [INT_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [INT_W-1:0] reg_rdata,
  output logic engine_busy_r,
  output logic prog_strobe_r,
  output logic [ADDR_W-1:0] prog_addr_r,
  output logic [DATA_W-1:0] prog_data_r,
  output logic [DATA_W-1:0] configuration_register_r,
  output logic [1:0] lock_bits_r,
  output logic irq
);
  cmd_state_t state_r, state_nxt;
  logic [CNT_W-1:0] count_r;
  logic [ADDR_W-1-BLOCK_LSB:0] first_block_r;
  logic block_bad_r;
  logic [INT_W-1:0] ev_nxt;
  logic [INT_W-1:0] status_w, enable_w;
  logic irq_w;
  logic [7:0] cmd;
  logic known;
  logic foreign_block_address;
  evt_if ev_bus ();

  assign cmd = wr_data[7:0];
  assign foreign_block_address = wr_addr[ADDR_W-1:BLOCK_LSB] != first_block_r;
  assign ev_bus.events = ev_nxt;
  assign irq = irq_w;

  // command code is part of the defined set
  always_comb
  begin
    known = (cmd == CMD_LOCK_SETUP) || (cmd == CMD_OTP_SETUP) || (cmd == CMD_BLOCK_PROTECT) ||
      (cmd == CMD_LOCK_DOWN) || (cmd == CMD_CFG_SET) || (cmd == CMD_BLANK_SETUP) ||
      (cmd == CMD_BLANK_CONFIRM) || (cmd == CMD_BP_SETUP) || (cmd == CMD_BP_CONFIRM) ||
      (cmd == CMD_BUFFERED_FACTORY_PROGRAM_SETUP) || (cmd == CMD_SUSPEND) || (cmd == CMD_READ_ARRAY);
  end

  // next state and event pulses
  always_comb
  begin
    state_nxt = state_r;
    ev_nxt = '0;
    case (state_r)
      ST_READY, ST_IS_READY:
      begin
        if (wr_strobe && cmd == CMD_BLANK_SETUP)
          state_nxt = ST_BLANK_SETUP;
        else if (wr_strobe && cmd == CMD_BUFFERED_FACTORY_PROGRAM_SETUP && !status_bit_zero)
          state_nxt = ST_BUFFERED_FACTORY_PROGRAM_SETUP;
        else if (wr_strobe && cmd == CMD_SUSPEND)
          state_nxt = ST_ERASE_PAUSED; // suspend pauses an erase run outside this block
        else if (wr_strobe && !known)
          state_nxt = ST_IS_READY;
      end
      ST_ERASE_PAUSED, ST_IS_ES:
      begin
        if (wr_strobe && cmd == CMD_BP_SETUP)
          state_nxt = ST_BP_SETUP_ES;
        else if (wr_strobe && cmd == CMD_LOCK_SETUP)
          state_nxt = ST_LOCK_SETUP_ES;
        else if (wr_strobe && !known)
          state_nxt = ST_IS_ES;
        else if (wr_strobe && known)
          state_nxt = ST_ERASE_PAUSED;
      end
      ST_BP_SETUP_ES:
      begin
        if (wr_strobe)
          state_nxt = ST_BP_LOAD1_ES; // count cycle, first data word always follows
      end
      ST_BP_LOAD1_ES:
      begin
        if (wr_strobe)
          state_nxt = (count_r == '0) ? ST_BP_CONFIRM_ES : ST_BP_LOAD2_ES;
      end
      ST_BP_LOAD2_ES:
      begin
        if (wr_strobe && count_r == '0)
          state_nxt = ST_BP_CONFIRM_ES;
      end
      ST_BP_CONFIRM_ES:
      begin
        if (wr_strobe)
        begin
          if (cmd != CMD_BP_CONFIRM)
          begin
            state_nxt = ST_ERASE_PAUSED;
            ev_nxt[EV_SEQ_ERR] = 1'b1;
          end
          else if (block_bad_r)
          begin
            state_nxt = ST_ERASE_PAUSED;
            ev_nxt[EV_BP_FAIL] = 1'b1;
          end
          else
            state_nxt = ST_BP_BUSY_ES;
        end
      end
      ST_BP_BUSY_ES, ST_IS_BP_BUSY_ES:
      begin
        if (engine_done)
        begin
          state_nxt = (state_r == ST_BP_BUSY_ES) ? ST_ERASE_PAUSED : ST_IS_ES;
          ev_nxt[EV_DONE] = 1'b1;
        end
        else if (wr_strobe && cmd == CMD_SUSPEND && state_r == ST_BP_BUSY_ES)
          state_nxt = ST_BP_SUSP_ES;
        else if (wr_strobe && !known)
          state_nxt = ST_IS_BP_BUSY_ES;
        else if (wr_strobe)
          state_nxt = ST_BP_BUSY_ES;
      end
      ST_BP_SUSP_ES, ST_IS_BP_SUSP_ES:
      begin
        if (wr_strobe && cmd == CMD_RESUME)
          state_nxt = ST_BP_BUSY_ES;
        else if (wr_strobe && !known)
          state_nxt = ST_IS_BP_SUSP_ES;
        else if (wr_strobe)
          state_nxt = ST_BP_SUSP_ES;
      end
      ST_BLANK_SETUP:
      begin
        if (wr_strobe)
        begin
          if (cmd == CMD_BLANK_CONFIRM)
            state_nxt = ST_BLANK_BUSY;
          else
          begin
            state_nxt = ST_READY;
            ev_nxt[EV_SEQ_ERR] = 1'b1;
          end
        end
      end
      ST_BLANK_BUSY, ST_IS_BLANK_BUSY:
      begin
        if (engine_done)
        begin
          state_nxt = (state_r == ST_BLANK_BUSY) ? ST_READY : ST_IS_READY;
          ev_nxt[EV_DONE] = 1'b1;
        end
        else if (wr_strobe && !known)
          state_nxt = ST_IS_BLANK_BUSY;
        else if (wr_strobe)
          state_nxt = ST_BLANK_BUSY;
      end
      ST_LOCK_SETUP_ES:
      begin
        if (wr_strobe)
        begin
          state_nxt = ST_ERASE_PAUSED;
          if (cmd == CMD_LOCK_SETUP || cmd == CMD_OTP_SETUP)
            ev_nxt[EV_SEQ_ERR] = 1'b1;
          else if (cmd != CMD_BLOCK_PROTECT && cmd != CMD_LOCK_DOWN && cmd != CMD_CFG_SET)
            ev_nxt[EV_LOCK_ERR] = 1'b1;
        end
      end
      ST_BUFFERED_FACTORY_PROGRAM_SETUP:
      begin
        if (wr_strobe)
          state_nxt = ST_BUFFERED_FACTORY_PROGRAM_BUSY;
      end
      ST_BUFFERED_FACTORY_PROGRAM_BUSY:
      begin
        if (wr_strobe && foreign_block_address && wr_data == BUFFERED_FACTORY_PROGRAM_EXIT_DATA)
        begin
          state_nxt = ST_READY;
          ev_nxt[EV_DONE] = 1'b1;
        end
        else if (wr_strobe)
          state_nxt = ST_BUFFERED_FACTORY_PROGRAM_BUSY;
      end
      default:
        state_nxt = ST_READY;
    endcase
  end

  // state register; reset to ready
  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= ST_READY;
    else
      state_r <= state_nxt;
  end

  // word counter for buffer loads
  always_ff @(posedge clk)
  begin
    if (rst)
      count_r <= '0;
    else if (wr_strobe && state_r == ST_BP_SETUP_ES)
      count_r <= wr_data[CNT_W-1:0];
    else if (wr_strobe && (state_r == ST_BP_LOAD1_ES || state_r == ST_BP_LOAD2_ES)
             && count_r != '0)
      count_r <= count_r - 1'b1;
  end

  // first block capture and foreign-block check
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_block_r <= '0;
      block_bad_r <= 1'b0;
    end
    else if (wr_strobe && (state_r == ST_BP_SETUP_ES || state_r == ST_BUFFERED_FACTORY_PROGRAM_SETUP))
    begin
      first_block_r <= wr_addr[ADDR_W-1:BLOCK_LSB];
      block_bad_r <= 1'b0;
    end
    else if (wr_strobe && (state_r == ST_BP_LOAD1_ES || state_r == ST_BP_LOAD2_ES)
             && foreign_block_address)
      block_bad_r <= 1'b1;
  end

  // program data strobe: buffer loads and factory data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prog_strobe_r <= 1'b0;
      prog_addr_r <= '0;
      prog_data_r <= '0;
    end
    else
    begin
      prog_strobe_r <= wr_strobe && (state_r == ST_BP_LOAD1_ES || state_r == ST_BP_LOAD2_ES
        || (state_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY && !foreign_block_address));
      prog_addr_r <= wr_addr;
      prog_data_r <= wr_data;
    end
  end

  // engine busy flag
  always_ff @(posedge clk)
  begin
    if (rst)
      engine_busy_r <= 1'b0;
    else
      engine_busy_r <= state_nxt == ST_BP_BUSY_ES || state_nxt == ST_IS_BP_BUSY_ES ||
        state_nxt == ST_BLANK_BUSY || state_nxt == ST_IS_BLANK_BUSY ||
        state_nxt == ST_BUFFERED_FACTORY_PROGRAM_BUSY;
  end

  // lock and configuration confirms; confirm cycles ignored while engine runs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_bits_r <= '0;
      configuration_register_r <= CFG_RESET;
    end
    else if (wr_strobe && state_r == ST_LOCK_SETUP_ES && !engine_busy_r)
    begin
      if (cmd == CMD_BLOCK_PROTECT)
        lock_bits_r[0] <= 1'b1;
      else if (cmd == CMD_LOCK_DOWN)
        lock_bits_r[1] <= 1'b1;
      else if (cmd == CMD_CFG_SET)
        configuration_register_r <= {wr_addr[DATA_W-1:0]};
    end
  end

  // register read port, data one cycle after strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_re)
    begin
      if (reg_addr == REG_STATUS)
        reg_rdata <= status_w;
      else if (reg_addr == REG_ENABLE)
        reg_rdata <= enable_w;
      else if (reg_addr == REG_STATE)
        reg_rdata <= state_r[INT_W-1:0];
      else
        reg_rdata <= '0;
    end
  end

  irq_unit u_irq (
    .clk(clk),
    .rst(rst),
    .ev(ev_bus.dst),
    .clr_we(reg_we && reg_addr == REG_CLEAR),
    .en_we(reg_we && reg_addr == REG_ENABLE),
    .wdata(reg_wdata),
    .status_r(status_w),
    .enable_r(enable_w),
    .irq_r(irq_w)
  );

  // wrong confirm lands in erase paused the next cycle
  property p_seq_err;
    @(posedge clk) disable iff (rst)
    (state_r == ST_BP_CONFIRM_ES && wr_strobe && cmd != CMD_BP_CONFIRM)
      |=> (state_r == ST_ERASE_PAUSED) ##1 status_w[EV_SEQ_ERR];
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("bad confirm not handled");

  property p_zero_count;
    @(posedge clk) disable iff (rst)
    (state_r == ST_BP_LOAD1_ES && wr_strobe && count_r == '0)
      |=> state_r == ST_BP_CONFIRM_ES;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count missed confirm");

  property p_buffered_factory_program_exit;
    @(posedge clk) disable iff (rst)
    (state_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY && wr_strobe && !(foreign_block_address && wr_data == BUFFERED_FACTORY_PROGRAM_EXIT_DATA))
      |=> state_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY && engine_busy_r;
  endproperty
  a_buffered_factory_program_exit: assert property (p_buffered_factory_program_exit) else $error("factory mode left early");

  property p_buffered_factory_program_gate;
    @(posedge clk) disable iff (rst)
    (state_r == ST_READY && wr_strobe && cmd == CMD_BUFFERED_FACTORY_PROGRAM_SETUP && status_bit_zero)
      |=> state_r != ST_BUFFERED_FACTORY_PROGRAM_SETUP;
  endproperty
  a_buffered_factory_program_gate: assert property (p_buffered_factory_program_gate) else $error("factory mode taken with bit set");

  property p_bp_done;
    @(posedge clk) disable iff (rst)
    (state_r == ST_BP_BUSY_ES && engine_done) |=> state_r == ST_ERASE_PAUSED ##1 !engine_busy_r;
  endproperty
  a_bp_done: assert property (p_bp_done) else $error("busy did not return");

  property p_fail;
    @(posedge clk) disable iff (rst)
    (state_r == ST_BP_CONFIRM_ES && block_bad_r && wr_strobe) |=> state_r != ST_BP_BUSY_ES;
  endproperty
  a_fail: assert property (p_fail) else $error("mixed block program started");

  property p_illegal;
    @(posedge clk) disable iff (rst)
    (state_r == ST_ERASE_PAUSED && wr_strobe && !known) |=> state_r == ST_IS_ES;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal code not trapped");

  property p_hold;
    @(posedge clk) disable iff (rst)
    (!wr_strobe && !engine_done) |=> $stable(state_r);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without input");

  property p_buffered_factory_program_data;
    @(posedge clk) disable iff (rst)
    (state_r == ST_BUFFERED_FACTORY_PROGRAM_BUSY && wr_strobe && !foreign_block_address)
      |=> prog_strobe_r && prog_data_r == $past(wr_data);
  endproperty
  a_buffered_factory_program_data: assert property (p_buffered_factory_program_data) else $error("factory write not data");
endmodule : cmd_lock_fsm

// [common/cmd_lock_pkg.sv]
// package: command codes, state enum, field layouts for the flash command lock state table
package cmd_lock_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 23;
  localparam int BLOCK_LSB = 16;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0] CMD_BLOCK_PROTECT = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN = 8'h2F;
  localparam logic [7:0] CMD_CFG_SET = 8'h03;
  localparam logic [7:0] CMD_BLANK_SETUP = 8'hBC;
  localparam logic [7:0] CMD_BLANK_CONFIRM = 8'hCB;
  localparam logic [7:0] CMD_BP_SETUP = 8'hE8;
  localparam logic [7:0] CMD_BP_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_BUFFERED_FACTORY_PROGRAM_SETUP = 8'h80;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [15:0] BUFFERED_FACTORY_PROGRAM_EXIT_DATA = 16'hFFFF;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int INT_W = 4;
  localparam int EV_SEQ_ERR = 0;
  localparam int EV_LOCK_ERR = 1;
  localparam int EV_DONE = 2;
  localparam int EV_BP_FAIL = 3;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CLEAR = 2'h1;
  localparam logic [1:0] REG_ENABLE = 2'h2;
  localparam logic [1:0] REG_STATE = 2'h3;
  typedef enum logic [4:0] {
    ST_ERASE_PAUSED, ST_BP_SETUP_ES, ST_BP_LOAD1_ES, ST_BP_LOAD2_ES, ST_BP_CONFIRM_ES,
    ST_BP_BUSY_ES, ST_IS_BP_BUSY_ES, ST_IS_ES, ST_BP_SUSP_ES, ST_IS_BP_SUSP_ES,
    ST_BLANK_SETUP, ST_BLANK_BUSY, ST_IS_BLANK_BUSY, ST_LOCK_SETUP_ES,
    ST_BUFFERED_FACTORY_PROGRAM_SETUP, ST_BUFFERED_FACTORY_PROGRAM_BUSY, ST_READY, ST_IS_READY
  } cmd_state_t;
endpackage : cmd_lock_pkg

// [common/evt_if.sv]
// interface: event pulses from the state machine to the interrupt unit
`timescale 1ns/1ns
interface evt_if;
  import cmd_lock_pkg::*;
  logic [INT_W-1:0] events;
  modport src (output events);
  modport dst (input events);
endinterface : evt_if

// [hdl/irq_unit.sv]
// module: sticky event status, write-one clear, enable mask and level interrupt
`timescale 1ns/1ns
module irq_unit
  import cmd_lock_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  evt_if.dst ev,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [INT_W-1:0] wdata,
  output logic [INT_W-1:0] status_r,
  output logic [INT_W-1:0] enable_r,
  output logic irq_r
);
  // sticky bits: a set in the clear cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
      status_r <= '0;
    else if (clr_we)
      status_r <= (status_r & ~wdata) | ev.events;
    else
      status_r <= status_r | ev.events;
  end

  // enable mask
  always_ff @(posedge clk)
  begin
    if (rst)
      enable_r <= '0;
    else if (en_we)
      enable_r <= wdata;
  end

  // level interrupt, registered
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_r & enable_r);
  end
endmodule : irq_unit

// [bench/host_model.sv]
// host model: issues flash bus write cycles to the command state machine
`timescale 1ns/1ns
module host_model
  import cmd_lock_pkg::*;
(
  input wire logic clk,
  input wire logic status_bit_zero,
  output logic wr_strobe,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data
);
  initial
  begin
    wr_strobe = 1'b0;
    wr_addr = '0;
    wr_data = '0;
  end

  // one write cycle; the released bus shows the inverse of the last value
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr_strobe <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_strobe <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask : write

  // factory mode is only started when the status bit allows it
  task automatic buffered_factory_program_start(input logic [ADDR_W-1:0] a, output bit ok);
    ok = (status_bit_zero === 1'b0);
    if (ok)
      write(a, {8'h00, CMD_BUFFERED_FACTORY_PROGRAM_SETUP});
  endtask : buffered_factory_program_start
endmodule : host_model

// [bench/testbench.sv]
// testbench: self-checking bench for the command state machine
`timescale 1ns/1ns
module testbench;
  import cmd_lock_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic engine_done = 1'b0;
  logic status_bit_zero = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [INT_W-1:0] reg_wdata = 4'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [INT_W-1:0] reg_rdata;
  logic wr_strobe, engine_busy_r, prog_strobe_r, irq;
  logic [ADDR_W-1:0] wr_addr, prog_addr_r;
  logic [DATA_W-1:0] wr_data, prog_data_r, configuration_register_r;
  logic [1:0] lock_bits_r;
  int n_fail = 0;
  int checks_done = 0;
  cmd_state_t exp_st;
  logic [3:0] exp_stat;
  logic [38:0] exp_q [$];
  logic [7:0] codes [6];

  cmd_lock_fsm u_dut (
    .clk(clk), .rst(rst), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .engine_done(engine_done), .status_bit_zero(status_bit_zero), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .engine_busy_r(engine_busy_r), .prog_strobe_r(prog_strobe_r),
    .prog_addr_r(prog_addr_r), .prog_data_r(prog_data_r),
    .configuration_register_r(configuration_register_r), .lock_bits_r(lock_bits_r),
    .irq(irq)
  );

  host_model u_host (
    .clk(clk), .status_bit_zero(status_bit_zero), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic reg_wr(input logic [1:0] a, input logic [INT_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : reg_wr

  // read data appear in the cycle after the strobe and hold until the next read
  task automatic reg_rd(input logic [1:0] a, output logic [INT_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd

  // compare state, status and busy against the model
  task automatic chk_model();
    logic [INT_W-1:0] v;
    reg_rd(REG_STATE, v);
    check("state", v, 4'(exp_st));
    reg_rd(REG_STATUS, v);
    check("status", v, exp_stat);
    check("busy", engine_busy_r, exp_st inside {ST_BP_BUSY_ES, ST_IS_BP_BUSY_ES, ST_BLANK_BUSY,
      ST_IS_BLANK_BUSY, ST_BUFFERED_FACTORY_PROGRAM_BUSY});
  endtask : chk_model

  // bounded wait for a program strobe, compared with the queued write
  task automatic wait_prog();
    int i;
    logic [38:0] e;
    e = exp_q.pop_front();
    #1;
    for (i = 0; i < 3 && prog_strobe_r !== 1'b1; i++)
      @(posedge clk) #1;
    check("prog_strobe", prog_strobe_r, 1'b1);
    check("prog_addr", prog_addr_r, e[38:16]);
    check("prog_data", prog_data_r, e[15:0]);
  endtask : wait_prog

  // buffered program in erase paused: setup, count n-1, n loads, confirm code
  task automatic bp_es(input logic [6:0] b, input logic [6:0] b2, input int n,
                       input logic [7:0] conf);
    logic [22:0] a;
    logic [15:0] d;
    u_host.write({b, 16'h0000}, {8'h00, CMD_BP_SETUP});
    u_host.write({b, 16'h0000}, 16'(n - 1));
    for (int k = 0; k < n; k++)
    begin
      a = {((k == n - 1) ? b2 : b), 16'($urandom)};
      d = 16'($urandom);
      exp_q.push_back({a, d});
      u_host.write(a, d);
      wait_prog();
    end
    u_host.write({b, 16'h0000}, {8'h00, conf});
  endtask : bp_es

  task automatic pulse_done();
    @(posedge clk);
    engine_done <= 1'b1;
    @(posedge clk);
    engine_done <= 1'b0;
  endtask : pulse_done

  // overall watchdog
  initial
  begin
    #5000000;
    check("timeout", 1, 0);
    close_out();
  end

  // main sequence
  initial
  begin
    logic [INT_W-1:0] v;
    logic [6:0] blk;
    logic [15:0] d;
    logic [22:0] a;
    bit ok;
    void'($urandom(32'hA59ED566));
    codes = '{CMD_LOCK_SETUP, CMD_OTP_SETUP, CMD_BLOCK_PROTECT, CMD_LOCK_DOWN,
              CMD_CFG_SET, 8'h55};
    exp_st = ST_READY;
    exp_stat = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_model();
    check("lock", lock_bits_r, 2'h0);
    check("cfg", configuration_register_r, CFG_RESET);
    reg_wr(REG_ENABLE, 4'hF);
    reg_rd(REG_ENABLE, v);
    check("enable", v, 4'hF);
    reg_wr(REG_STATUS, 4'hF);
    chk_model();
    // wrong code after blank check setup
    u_host.write(23'h0, {8'h00, CMD_BLANK_SETUP});
    u_host.write(23'h0, 16'h0055);
    exp_stat[EV_SEQ_ERR] = 1'b1;
    repeat (2) @(posedge clk);
    chk_model();
    check("irq", irq, 1'b1);
    reg_wr(REG_CLEAR, 4'hF);
    exp_stat = 4'h0;
    repeat (2) @(posedge clk);
    check("irq", irq, 1'b0);
    // lock and configuration codes while the engine runs
    u_host.write(23'h0, {8'h00, CMD_BLANK_SETUP});
    u_host.write(23'h0, {8'h00, CMD_BLANK_CONFIRM});
    exp_st = ST_BLANK_BUSY;
    foreach (codes[k])
    begin
      u_host.write(23'h00ABCD, {8'h00, codes[k]});
      if (k == 5)
        exp_st = ST_IS_BLANK_BUSY;
      chk_model();
      check("lock", lock_bits_r, 2'h0);
      check("cfg", configuration_register_r, CFG_RESET);
    end
    pulse_done();
    exp_st = ST_IS_READY;
    exp_stat[EV_DONE] = 1'b1;
    repeat (2) @(posedge clk);
    chk_model();
    check("irq", irq, 1'b1);
    reg_wr(REG_ENABLE, 4'h0);
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    reg_wr(REG_CLEAR, 4'hF);
    reg_wr(REG_ENABLE, 4'hF);
    exp_stat = 4'h0;
    // mid-run reset: back to ready, enable cleared
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    exp_st = ST_READY;
    chk_model();
    reg_rd(REG_ENABLE, v);
    check("enable", v, 4'h0);
    // factory mode refused while the status bit is set
    status_bit_zero <= 1'b1;
    @(posedge clk);
    u_host.buffered_factory_program_start(23'h0, ok);
    check("host", ok, 1'b0);
    u_host.write(23'h0, {8'h00, CMD_BUFFERED_FACTORY_PROGRAM_SETUP});
    u_host.write(23'h010000, 16'h1234);
    repeat (3) @(posedge clk);
    check("busy", engine_busy_r, 1'b0);
    reg_rd(REG_STATE, v);
    check("state", v, 4'(ST_IS_READY));
    reg_wr(REG_CLEAR, 4'hF);
    // factory mode accepted; command codes are data
    status_bit_zero <= 1'b0;
    @(posedge clk);
    blk = 7'($urandom_range(0, 126));
    u_host.buffered_factory_program_start({blk, 16'h0000}, ok);
    check("host", ok, 1'b1);
    u_host.write({blk, 16'h0000}, 16'h0000);
    repeat (3) @(posedge clk);
    for (int k = 0; k < 8; k++)
    begin
      a = {blk, 16'($urandom)};
      d = (k < 6) ? {8'h00, codes[k]} : ((k == 6) ? 16'($urandom) : BUFFERED_FACTORY_PROGRAM_EXIT_DATA);
      exp_q.push_back({a, d});
      u_host.write(a, d);
      wait_prog();
      check("busy", engine_busy_r, 1'b1);
    end
    u_host.write({7'(blk + 7'h01), 16'($urandom)}, BUFFERED_FACTORY_PROGRAM_EXIT_DATA);
    repeat (3) @(posedge clk);
    check("busy", engine_busy_r, 1'b0);
    reg_rd(REG_STATE, v);
    check("state", v, 4'(ST_READY));
    // erase paused: lock confirms, illegal code, buffered program flows
    reg_wr(REG_CLEAR, 4'hF);
    exp_stat = 4'h0;
    u_host.write(23'h0, {8'h00, CMD_SUSPEND});
    exp_st = ST_ERASE_PAUSED;
    for (int k = 2; k < 6; k++)
    begin
      u_host.write(23'h01ABCD, {8'h00, CMD_LOCK_SETUP});
      u_host.write(23'h01ABCD, {8'h00, codes[k]});
    end
    exp_stat[EV_LOCK_ERR] = 1'b1;
    check("lock", lock_bits_r, 2'h3);
    check("cfg", configuration_register_r, 16'hABCD);
    chk_model();
    u_host.write(23'h0, 16'h0055);
    exp_st = ST_IS_ES;
    chk_model();
    bp_es(blk, blk, 1, CMD_BP_CONFIRM);
    u_host.write(23'h0, {8'h00, CMD_LOCK_SETUP});
    exp_st = ST_BP_BUSY_ES;
    chk_model();
    pulse_done();
    exp_st = ST_ERASE_PAUSED;
    exp_stat[EV_DONE] = 1'b1;
    chk_model();
    bp_es(blk, blk, 3, 8'h55);
    exp_stat[EV_SEQ_ERR] = 1'b1;
    chk_model();
    bp_es(blk, 7'(blk + 7'h01), 2, CMD_BP_CONFIRM);
    exp_stat[EV_BP_FAIL] = 1'b1;
    chk_model();
    close_out();
  end
endmodule : testbench
